// File: verilog/adc_seq_pkg.sv
// constants and types for the main converter round-robin sequencer
package adc_seq_pkg;

  // ****************************************************************
  // slot map
  // ****************************************************************
  localparam int          NUM_SLOTS   = 24;
  localparam logic [4:0]  SLOT_DIE    = 5'h00;
  localparam logic [4:0]  SLOT_BREF   = 5'h01;
  localparam logic [4:0]  SLOT_CELL0  = 5'h02;
  localparam logic [4:0]  SLOT_CURR   = 5'h12;
  localparam logic [4:0]  SLOT_GPIO   = 5'h13;
  localparam logic [4:0]  SLOT_LAST   = 5'h17;
  localparam int          NUM_CELLS   = 16;
  localparam logic [4:0]  MIN_CELLS   = 5'h06;
  localparam logic [4:0]  MAX_CELLS   = 5'h10;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam int          CLK_PERIOD_NS = 4;
  localparam int          SLOT_TIME_NS  = 8000;
  localparam int          PASS_TIME_NS  = 192000;
  localparam int          SLOT_CYCLES   = SLOT_TIME_NS / CLK_PERIOD_NS;
  localparam logic [3:0]  READY_PASSES  = 4'h8;

  // ****************************************************************
  // register map (byte addresses) and fields
  // ****************************************************************
  localparam logic [11:0] ADDR_CTRL      = 12'h000;
  localparam logic [11:0] ADDR_CONFIG    = 12'h004;
  localparam logic [11:0] ADDR_STATUS    = 12'h008;
  localparam logic [11:0] ADDR_RES_BASE  = 12'h100;
  localparam logic [11:0] ADDR_RES_LAST  = 12'h1BC;
  localparam logic [15:0] RESULT_DEFAULT = 16'h8000;

  localparam int CTRL_MAIN_EN  = 0;
  localparam int CTRL_GO       = 1;
  localparam int CTRL_LPF_CELL = 2;
  localparam int CTRL_LPF_SR   = 3;
  localparam int CTRL_AUX_EN   = 4;
  localparam int CTRL_CS_EN    = 5;
  localparam int CTRL_CONT     = 6;
  localparam int CTRL_SHIFT_LO = 8;
  localparam int CTRL_PWR_LO   = 12;
  localparam logic [31:0] CTRL_WMASK = 32'h0000_377D;

  localparam int CFG_CELLS_LO = 0;
  localparam int CFG_GMASK_LO = 8;
  localparam int CFG_DLY_LO   = 16;
  localparam logic [31:0] CFG_WMASK = 32'h003F_FF0F;

  localparam int STAT_RUN   = 0;
  localparam int STAT_READY = 1;
  localparam int STAT_GIDX  = 4;
  localparam int STAT_SLOT  = 8;

  typedef enum logic [1:0] {
    PWR_ACTIVE   = 2'b00,
    PWR_SLEEP    = 2'b01,
    PWR_SHUTDOWN = 2'b10
  } power_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_DELAY = 2'b01,
    ST_RUN   = 2'b10
  } seq_state_e;

endpackage

// File: verilog/main_adc_round_robin_sequencer.sv
// round-robin sequencer and result registers for the main converter
module main_adc_round_robin_sequencer #(
  parameter int SLOT_CYCLES = adc_seq_pkg::SLOT_CYCLES
) (
  // apb slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // converter front end
  output logic      [4:0]  mux_slot,
  output logic      [2:0]  gpio_select,
  output logic             conv_start,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_data,
  // analogue enables
  output logic             main_adc_enable,
  output logic             aux_adc_enable,
  output logic             cs_adc_enable,
  output logic             level_shift_enable,
  // status
  output logic             main_results_ready_flag
);

  // ****************************************************************
  // elaboration checks and helpers
  // ****************************************************************
  if (SLOT_CYCLES < 4 || SLOT_CYCLES > 65535) begin : g_chk
    $error("SLOT_CYCLES out of range");
  end

  // every check below runs on pclk and rests while reset is low
  default clocking chk_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // cell count field: 0 stands for sixteen, small values clamp to six
  function automatic logic [4:0] cell_count(input logic [3:0] f);
    logic [4:0] c;
    c = {1'b0, f};
    if (f == 4'h0) c = adc_seq_pkg::MAX_CELLS;
    else if (c < adc_seq_pkg::MIN_CELLS) c = adc_seq_pkg::MIN_CELLS;
    return c;
  endfunction

  // whether a slot is measured in this pass
  function automatic logic slot_active(input logic [4:0] s,
                                       input logic [4:0] cells,
                                       input logic [7:0] gmask,
                                       input logic [2:0] gidx);
    logic a;
    a = 1'b0;
    if (s < adc_seq_pkg::SLOT_CELL0) a = 1'b1;
    else if (s < adc_seq_pkg::SLOT_CURR)
      a = (s - adc_seq_pkg::SLOT_CELL0) < cells;
    else if (s == adc_seq_pkg::SLOT_CURR) a = 1'b1;
    else if (s == adc_seq_pkg::SLOT_GPIO) a = gmask[gidx];
    return a;
  endfunction

  // single-pole filter step, coefficient 2^-k
  function automatic logic [15:0] lpf_step(input logic [15:0] prev,
                                           input logic [15:0] x,
                                           input logic [2:0]  k);
    logic signed [16:0] d;
    d = $signed({x[15], x}) - $signed({prev[15], prev});
    d = d >>> k;
    return prev + d[15:0];
  endfunction

  // ****************************************************************
  // registers and state
  // ****************************************************************
  logic [31:0] ctrl_r, ctrl_nxt, cfg_r, cfg_nxt, prdata_r, prdata_nxt;
  logic        err_r, err_nxt;
  adc_seq_pkg::seq_state_e st_r, st_nxt;
  logic [4:0]  slot_r, slot_nxt, lat_cells_r, lat_cells_nxt;
  logic [15:0] tick_r, tick_nxt;
  logic [3:0]  pass_r, pass_nxt;
  logic [2:0]  gidx_r, gidx_nxt, lat_shift_r, lat_shift_nxt;
  logic [7:0]  lat_gmask_r, lat_gmask_nxt;
  logic [5:0]  dly_r, dly_nxt;
  logic        lat_lpf_c_r, lat_lpf_c_nxt, lat_lpf_s_r, lat_lpf_s_nxt;
  logic        lat_cont_r, lat_cont_nxt, done_r, done_nxt;
  logic        start_r, start_nxt, ready_r, ready_nxt;
  logic [15:0] res_r   [adc_seq_pkg::NUM_SLOTS];
  logic [15:0] res_nxt [adc_seq_pkg::NUM_SLOTS];
  logic [7:0]  lo_r    [adc_seq_pkg::NUM_SLOTS];
  logic [7:0]  lo_nxt  [adc_seq_pkg::NUM_SLOTS];
  logic [23:0] hold_r, hold_nxt, first_r, first_nxt;

  logic        setup, access, go, store;
  logic        res_hit, is_lo;
  logic [4:0]  res_idx;
  logic [11:0] roff;
  logic [15:0] filt;

  // ****************************************************************
  // apb decode
  // ****************************************************************
  // zero-wait slave; read data is captured in the setup cycle so that
  // it comes from a flip-flop in the access cycle
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign pready  = 1'b1;
  assign prdata  = prdata_r;
  assign pslverr = err_r & access;
  assign roff    = paddr - adc_seq_pkg::ADDR_RES_BASE;
  assign res_hit = paddr >= adc_seq_pkg::ADDR_RES_BASE &&
                   paddr <= adc_seq_pkg::ADDR_RES_LAST &&
                   paddr[1:0] == 2'b00;
  assign res_idx = roff[7:3];
  assign is_lo   = roff[2];
  assign go      = access & pwrite & paddr == adc_seq_pkg::ADDR_CTRL &
                   pwdata[adc_seq_pkg::CTRL_GO] &
                   pwdata[adc_seq_pkg::CTRL_MAIN_EN];

  // control registers and read mux
  always_comb begin
    ctrl_nxt   = ctrl_r;
    cfg_nxt    = cfg_r;
    prdata_nxt = prdata_r;
    err_nxt    = err_r;
    if (access && pwrite && paddr == adc_seq_pkg::ADDR_CTRL)
      ctrl_nxt = pwdata & adc_seq_pkg::CTRL_WMASK;
    if (access && pwrite && paddr == adc_seq_pkg::ADDR_CONFIG)
      cfg_nxt = pwdata & adc_seq_pkg::CFG_WMASK;
    if (setup) begin
      err_nxt    = 1'b0;
      prdata_nxt = 32'h0000_0000;
      if (paddr == adc_seq_pkg::ADDR_CTRL) prdata_nxt = ctrl_r;
      else if (paddr == adc_seq_pkg::ADDR_CONFIG) prdata_nxt = cfg_r;
      else if (paddr == adc_seq_pkg::ADDR_STATUS) begin
        prdata_nxt[adc_seq_pkg::STAT_RUN]   = st_r != adc_seq_pkg::ST_IDLE;
        prdata_nxt[adc_seq_pkg::STAT_READY] = ready_r;
        prdata_nxt[adc_seq_pkg::STAT_GIDX +: 3] = gidx_r;
        prdata_nxt[adc_seq_pkg::STAT_SLOT +: 5] = slot_r;
      end else if (res_hit && !pwrite)
        prdata_nxt[7:0] = is_lo ? lo_r[res_idx] : res_r[res_idx][15:8];
      else if (!res_hit) err_nxt = 1'b1;  // unmapped address
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= 32'h0000_0000;
      cfg_r    <= 32'h0000_0000;
      prdata_r <= 32'h0000_0000;
      err_r    <= 1'b0;
    end else begin
      ctrl_r   <= ctrl_nxt;
      cfg_r    <= cfg_nxt;
      prdata_r <= prdata_nxt;
      err_r    <= err_nxt;
    end
  end

  // independent enables; level shifter only powered when active
  assign main_adc_enable = ctrl_r[adc_seq_pkg::CTRL_MAIN_EN];
  assign aux_adc_enable  = ctrl_r[adc_seq_pkg::CTRL_AUX_EN];
  assign cs_adc_enable   = ctrl_r[adc_seq_pkg::CTRL_CS_EN];
  assign level_shift_enable = ctrl_r[adc_seq_pkg::CTRL_PWR_LO +: 2] ==
                              adc_seq_pkg::PWR_ACTIVE;

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // a conversion is taken once per slot; late or extra done pulses of
  // an inactive slot are dropped so that the slot costs time only
  assign store = st_r == adc_seq_pkg::ST_RUN && conv_done && !done_r &&
                 slot_active(slot_r, lat_cells_r, lat_gmask_r, gidx_r);

  always_comb begin
    st_nxt = st_r;   slot_nxt = slot_r;   tick_nxt = tick_r;
    pass_nxt = pass_r;   gidx_nxt = gidx_r;   dly_nxt = dly_r;
    done_nxt = done_r | store;   start_nxt = 1'b0;   ready_nxt = ready_r;
    lat_cells_nxt = lat_cells_r;   lat_gmask_nxt = lat_gmask_r;
    lat_shift_nxt = lat_shift_r;   lat_lpf_c_nxt = lat_lpf_c_r;
    lat_lpf_s_nxt = lat_lpf_s_r;   lat_cont_nxt = lat_cont_r;
    case (st_r)
      adc_seq_pkg::ST_IDLE: begin
      end
      adc_seq_pkg::ST_DELAY: begin
        tick_nxt = tick_r + 16'h0001;
        if (tick_r == 16'(SLOT_CYCLES - 1)) begin
          tick_nxt = 16'h0000;
          dly_nxt  = dly_r - 6'h01;
          if (dly_r == 6'h01) begin
            st_nxt    = adc_seq_pkg::ST_RUN;
            start_nxt = slot_active(adc_seq_pkg::SLOT_DIE, lat_cells_r,
                                    lat_gmask_r, gidx_r);
          end
        end
      end
      adc_seq_pkg::ST_RUN: begin
        tick_nxt = tick_r + 16'h0001;
        if (tick_r == 16'(SLOT_CYCLES - 1)) begin
          tick_nxt = 16'h0000;
          done_nxt = 1'b0;
          slot_nxt = slot_r + 5'h01;
          if (slot_r == adc_seq_pkg::SLOT_LAST) begin
            slot_nxt = adc_seq_pkg::SLOT_DIE;
            gidx_nxt = gidx_r + 3'h1;
            if (pass_r != adc_seq_pkg::READY_PASSES)
              pass_nxt = pass_r + 4'h1;
            if (pass_r == adc_seq_pkg::READY_PASSES - 4'h1)
              ready_nxt = 1'b1;
            if (!lat_cont_r) st_nxt = adc_seq_pkg::ST_IDLE;
          end
          // inactive slots get no start pulse but keep their period
          start_nxt = st_nxt == adc_seq_pkg::ST_RUN &&
                      slot_active(slot_nxt, lat_cells_r, lat_gmask_r,
                                  gidx_nxt);
        end
      end
      default: st_nxt = adc_seq_pkg::ST_IDLE;
    endcase
    if (go) begin
      lat_cells_nxt = cell_count(cfg_r[adc_seq_pkg::CFG_CELLS_LO +: 4]);
      lat_gmask_nxt = cfg_r[adc_seq_pkg::CFG_GMASK_LO +: 8];
      dly_nxt       = cfg_r[adc_seq_pkg::CFG_DLY_LO +: 6];
      lat_shift_nxt = pwdata[adc_seq_pkg::CTRL_SHIFT_LO +: 3];
      lat_lpf_c_nxt = pwdata[adc_seq_pkg::CTRL_LPF_CELL];
      lat_lpf_s_nxt = pwdata[adc_seq_pkg::CTRL_LPF_SR];
      lat_cont_nxt  = pwdata[adc_seq_pkg::CTRL_CONT];
      slot_nxt = adc_seq_pkg::SLOT_DIE;   tick_nxt = 16'h0000;
      pass_nxt = 4'h0;   gidx_nxt = 3'h0;   ready_nxt = 1'b0;
      done_nxt = 1'b0;
      if (cfg_r[adc_seq_pkg::CFG_DLY_LO +: 6] == 6'h00) begin
        st_nxt    = adc_seq_pkg::ST_RUN;
        start_nxt = 1'b1;                             // die slot active
      end else begin
        st_nxt    = adc_seq_pkg::ST_DELAY;
        start_nxt = 1'b0;
      end
    end else if (!ctrl_r[adc_seq_pkg::CTRL_MAIN_EN]) begin
      st_nxt    = adc_seq_pkg::ST_IDLE;
      start_nxt = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= adc_seq_pkg::ST_IDLE;  slot_r <= 5'h00;  tick_r <= 16'h0000;
      pass_r <= 4'h0;  gidx_r <= 3'h0;  dly_r <= 6'h00;  done_r <= 1'b0;
      start_r <= 1'b0;  ready_r <= 1'b0;
      lat_cells_r <= adc_seq_pkg::MAX_CELLS;
      lat_gmask_r <= 8'h00;  lat_shift_r <= 3'h0;  lat_lpf_c_r <= 1'b0;
      lat_lpf_s_r <= 1'b0;  lat_cont_r <= 1'b0;
    end else begin
      st_r <= st_nxt;  slot_r <= slot_nxt;  tick_r <= tick_nxt;
      pass_r <= pass_nxt;  gidx_r <= gidx_nxt;  dly_r <= dly_nxt;
      done_r <= done_nxt;  start_r <= start_nxt;  ready_r <= ready_nxt;
      lat_cells_r <= lat_cells_nxt;  lat_gmask_r <= lat_gmask_nxt;
      lat_shift_r <= lat_shift_nxt;  lat_lpf_c_r <= lat_lpf_c_nxt;
      lat_lpf_s_r <= lat_lpf_s_nxt;  lat_cont_r <= lat_cont_nxt;
    end
  end

  assign mux_slot    = slot_r;
  assign gpio_select = gidx_r;
  assign conv_start  = start_r;
  assign main_results_ready_flag = ready_r;

  // ****************************************************************
  // result registers
  // ****************************************************************
  // die temperature is stored as converted, zero code is zero degrees
  assign filt = lpf_step(res_r[slot_r], conv_data, lat_shift_r);

  always_comb begin
    res_nxt   = res_r;
    lo_nxt    = lo_r;
    hold_nxt  = hold_r;
    first_nxt = first_r;
    if (go) begin
      for (int i = 0; i < adc_seq_pkg::NUM_SLOTS; i++) begin
        res_nxt[i] = adc_seq_pkg::RESULT_DEFAULT;
        lo_nxt[i]  = adc_seq_pkg::RESULT_DEFAULT[7:0];
      end
      hold_nxt  = 24'h00_0000;
      first_nxt = 24'hFF_FFFF;
    end else begin
      // low-byte read releases the hold and shows the newest value
      if (access && !pwrite && res_hit && is_lo) begin
        hold_nxt[res_idx] = 1'b0;
        lo_nxt[res_idx]   = res_r[res_idx][7:0];
      end
      // hold is taken in setup so a refresh cannot slip in before it
      if (setup && !pwrite && res_hit && !is_lo)
        hold_nxt[res_idx] = 1'b1;
      if (store) begin
        first_nxt[slot_r] = 1'b0;
        if (((slot_r >= adc_seq_pkg::SLOT_CELL0 &&
              slot_r <  adc_seq_pkg::SLOT_CURR) && lat_lpf_c_r ||
             slot_r == adc_seq_pkg::SLOT_CURR && lat_lpf_s_r) &&
            !first_r[slot_r])
          res_nxt[slot_r] = filt;
        else
          res_nxt[slot_r] = conv_data;
        // the hold as it stands after this edge decides, so a refresh in
        // the very cycle of a high-byte read cannot split the pair
        if (!hold_nxt[slot_r])
          lo_nxt[slot_r] = res_nxt[slot_r][7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < adc_seq_pkg::NUM_SLOTS; i++) begin
        res_r[i] <= adc_seq_pkg::RESULT_DEFAULT;
        lo_r[i]  <= adc_seq_pkg::RESULT_DEFAULT[7:0];
      end
      hold_r  <= 24'h00_0000;
      first_r <= 24'hFF_FFFF;
    end else begin
      res_r   <= res_nxt;
      lo_r    <= lo_nxt;
      hold_r  <= hold_nxt;
      first_r <= first_nxt;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  sequence s_last_slot_ends;
    st_r == adc_seq_pkg::ST_RUN && slot_r == adc_seq_pkg::SLOT_LAST &&
    tick_r == 16'(SLOT_CYCLES - 1) && !go;
  endsequence

  chk_slot_advance: assert property (
    st_r == adc_seq_pkg::ST_RUN && tick_r == 16'(SLOT_CYCLES - 1) && !go &&
    ctrl_r[adc_seq_pkg::CTRL_MAIN_EN] && slot_r != adc_seq_pkg::SLOT_LAST
    |=> slot_r == $past(slot_r) + 5'h01 && tick_r == 16'h0000)
    else $error("slot did not advance at period end");
  chk_slot_hold: assert property (
    tick_r != 16'(SLOT_CYCLES - 1) && !go |=> $stable(slot_r))
    else $error("slot changed inside its period");
  chk_gpio_wrap: assert property (
    s_last_slot_ends ##0 ctrl_r[adc_seq_pkg::CTRL_MAIN_EN]
    |=> gidx_r == $past(gidx_r) + 3'h1 && slot_r == adc_seq_pkg::SLOT_DIE)
    else $error("gpio index did not step after pass");
  chk_preset_value: assert property (
    go |=> res_r[0] == adc_seq_pkg::RESULT_DEFAULT && !ready_r)
    else $error("results not preset on start");
  chk_inactive_cell: assert property (
    st_r != adc_seq_pkg::ST_IDLE && lat_cells_r < adc_seq_pkg::MAX_CELLS
    |-> res_r[17] == adc_seq_pkg::RESULT_DEFAULT)
    else $error("inactive cell result changed");
  chk_no_start: assert property (
    conv_start |-> slot_active(slot_r, lat_cells_r, lat_gmask_r, gidx_r))
    else $error("start issued for inactive slot");
  chk_lo_frozen: assert property (
    hold_r[adc_seq_pkg::SLOT_CELL0] && !go &&
    !(access && res_hit && is_lo && res_idx == adc_seq_pkg::SLOT_CELL0)
    |=> $stable(lo_r[adc_seq_pkg::SLOT_CELL0]))
    else $error("low byte refreshed while held");
  chk_ready_flag: assert property (
    $rose(ready_r) |-> pass_r == adc_seq_pkg::READY_PASSES)
    else $error("ready set before eight passes");
  chk_raw_store: assert property (
    store && first_r[slot_r] && !go
    |=> res_r[$past(slot_r)] == $past(conv_data))
    else $error("first sample not loaded directly");
  chk_shifter_off: assert property (
    ctrl_r[adc_seq_pkg::CTRL_PWR_LO +: 2] != adc_seq_pkg::PWR_ACTIVE
    |-> !level_shift_enable)
    else $error("level shifter on outside active mode");

endmodule

// File: verif/adc_front_end_model.sv
// behavioural analogue front end answering conversion requests
module adc_front_end_model (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // request side
  input  wire logic        conv_start,
  input  wire logic [15:0] sample,
  input  wire logic        slow,
  // answer side
  output logic             conv_done,
  output logic      [15:0] conv_data
);
  timeunit 1ns;
  timeprecision 1ns;
  int          wait_n;
  logic [15:0] held;
  // one answer per request, prompt or slow, always inside the slot
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_n    <= 0;
      conv_done <= 1'b0;
      conv_data <= 16'h0000;
    end else begin
      conv_done <= 1'b0;
      conv_data <= ~conv_data; // no stale value between answers
      if (conv_start) begin
        wait_n <= slow ? 3 : 1;
        held   <= sample;
      end else if (wait_n == 1) begin
        conv_done <= 1'b1;
        conv_data <= held;
        wait_n    <= 0;
      end else if (wait_n > 1) begin
        wait_n <= wait_n - 1;
      end
    end
  end
endmodule

// File: verif/test_main_adc_round_robin_sequencer.sv
// self-checking bench for the main converter round-robin sequencer
module test_main_adc_round_robin_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  // ********************
  // signals and tables
  // ********************
  localparam int SC = 8; // short slots keep the run brief
  `define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
    fails++; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
  logic        penable = 1'b0, pwrite = 1'b0, chk_r = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic        pready, pslverr, conv_start, conv_done, rdy;
  logic        main_en, aux_en, cs_en, ls_en;
  logic [4:0]  mux_slot;
  logic [2:0]  gpio_select, gprev;
  logic [15:0] conv_data, old, lfsr = 16'h06D1, val[24];
  logic [8:0]  exp_q[$];
  logic [31:0] ctl_t[3] = '{32'h0000_1010, 32'h0000_2021, 32'h0000_0031};
  logic [3:0]  en_t[3] = '{4'b0100, 4'b1010, 4'b1111};
  wire  [3:0]  ens = {main_en, aux_en, cs_en, ls_en};
  int          fails = 0, samples_checked = 0, cyc = 0, t0 = 0, tdone = 0;
  int          ncell = 6, rel, sl, ps;
  bit          running = 0, gok = 0, digital_lowpass = 0;
  bit   [23:0] seen = '0;
  logic [2:0]  kf = 3'h0;

  main_adc_round_robin_sequencer #(.SLOT_CYCLES(SC)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mux_slot(mux_slot),
    .gpio_select(gpio_select), .conv_start(conv_start),
    .conv_done(conv_done), .conv_data(conv_data), .main_adc_enable(main_en),
    .aux_adc_enable(aux_en), .cs_adc_enable(cs_en),
    .level_shift_enable(ls_en), .main_results_ready_flag(rdy));
  adc_front_end_model i_fe (
    .pclk(pclk), .presetn(presetn), .conv_start(conv_start),
    .sample(lfsr), .slow(lfsr[0]), .conv_done(conv_done),
    .conv_data(conv_data));

  function automatic logic [15:0] nxt(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic bit act(int s, int n);
    return s < 2 || s == 18 || s == 19 || s < n + 2;
  endfunction
  function automatic logic [11:0] res(int s, bit lo);
    return adc_seq_pkg::ADDR_RES_BASE + 12'(8 * s) + (lo ? 12'h4 : 12'h0);
  endfunction
  // single-pole filter with coefficient 2^-k, signed arithmetic
  function automatic logic [15:0] flt(logic [15:0] p, logic [15:0] x,
                                      logic [2:0] k);
    logic signed [16:0] d;
    d = ($signed({x[15], x}) - $signed({p[15], p})) >>> k;
    return p + d[15:0];
  endfunction

  // clock, cycle count and random samples
  always #2 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc  <= cyc + 1;
    lfsr <= nxt(lfsr);
  end

  // ********************
  // bus tasks
  // ********************
  // idle edge first, so no signal is assigned twice in one step
  task automatic apb(input bit wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [8:0] e, input bit c);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; chk_r <= c;
    @(posedge pclk);
    penable <= 1'b1;
    if (c) exp_q.push_back(e);
    do @(posedge pclk); while (pready !== 1'b1);
    tdone = cyc;
    psel <= 1'b0; penable <= 0;
  endtask
  task automatic start(input logic [31:0] cfg, ctl, input int n);
    apb(1, adc_seq_pkg::ADDR_CONFIG, cfg, 9'h000, 0);
    foreach (val[s]) val[s] = 16'h8000;
    ncell = n;
    gok = 0;
    seen = '0;
    digital_lowpass = ctl[2];
    kf = ctl[10:8];
    apb(1, adc_seq_pkg::ADDR_CTRL, ctl, 9'h000, 0);
    t0 = tdone + 1 + SC * int'(cfg[21:16]); // start delay in slots
    running = 1;
  endtask
  task automatic wait_slot3();
    do @(posedge pclk); while (conv_start !== 1'b1 || mux_slot !== 5'h03);
  endtask

  // ********************
  // monitors
  // ********************
  // read data against the oldest note in the queue
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && chk_r)
      `CHK({pslverr, prdata[7:0]}, exp_q.pop_front())
  end
  // slot timing worked out from the start edge, not from the design
  always @(posedge pclk) begin
    if (running) begin
      rel = cyc - t0;
      sl  = (rel / SC) % 24;
      ps  = rel / (SC * 24);
      if (conv_start === 1'b1) begin
        `CHK(mux_slot, 5'(sl))
        `CHK(rel % SC, 0)
        `CHK(act(sl, ncell), 1'b1)
        if (sl == 19 && gok) `CHK(gpio_select, 3'(gprev + 3'h1))
        if (sl == 19) begin
          gprev = gpio_select;
          gok = 1;
        end
        if (sl == 0) `CHK(rdy, 1'(ps >= 8))
      end
      if (conv_done === 1'b1) begin
        if (digital_lowpass && sl >= 2 && sl < 18 && seen[sl])
          val[sl] = flt(val[sl], conv_data, kf);
        else
          val[sl] = conv_data;
        seen[sl] = 1'b1;
      end
    end
  end

  // ********************
  // scenarios and verdict
  // ********************
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    `CHK(ens, 4'b0001)
    apb(0, res(2, 0), 0, 9'h080, 1);
    apb(0, 12'h200, 0, 9'h100, 1); // unmapped place is refused
    // single pass, six cells: skipped slots keep the default
    start(32'h0001_FF06, 32'h0000_0003, 6); // one slot of start delay
    repeat (24 * SC + 16) @(posedge pclk);
    running = 0;
    foreach (val[s]) begin
      apb(0, res(s, 0), 0, {1'b0, val[s][15:8]}, 1);
      apb(0, res(s, 1), 0, {1'b0, val[s][7:0]}, 1);
    end
    apb(0, adc_seq_pkg::ADDR_STATUS, 0, 9'h010, 1);
    // continuous, sixteen cells, cell filter on; restart presets results
    start(32'h0000_FF00, 32'h0000_0147, 16);
    apb(0, res(2, 0), 0, 9'h080, 1);
    apb(0, res(2, 1), 0, 9'h000, 1);
    wait_slot3();
    old = val[2];
    apb(0, res(2, 0), 0, {1'b0, old[15:8]}, 1);
    wait_slot3();
    apb(0, res(2, 1), 0, {1'b0, old[7:0]}, 1);
    apb(0, res(2, 1), 0, {1'b0, val[2][7:0]}, 1);
    while (cyc - t0 < 10 * 24 * SC) @(posedge pclk);
    running = 0;
    foreach (ctl_t[i]) begin
      apb(1, adc_seq_pkg::ADDR_CTRL, ctl_t[i], 9'h000, 0);
      @(posedge pclk);
      `CHK(ens, en_t[i])
    end
    stop_test();
  end
endmodule
